// ---- core/slv_pkg.sv ----
// Summary of operation
// - three-bit level field picks one of eight trip levels, 000 lowest, 111 highest
// - low-supply flag reads one below threshold, zero above it
// - low-supply flag sits at control bit 5, read-only, writes ignored
// - detector-on bit one powers detector, zero switches it off
// - control bits 7 to 6 and bit 3 always read zero
// - reference for the detector turns on automatically with the detector
// - detector keeps running in sleep or idle while enabled
// - low-supply flag filtered, a change passes only once two successive samples agree
// - detector request feeds the shared interrupt, flag also pollable
// - detector request raised only after fixed delay from flag rise
// - in power-down a supply drop sets request flag and wakes core
// - any zero-to-one request flag transition during power-down wakes, enable irrelevant
// - servicing clears only the shared flag, detector request stays set
package slv_pkg;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int unsigned CLK_PERIOD_NS  = 100;
	localparam int unsigned SETTLE_TIME_NS = 100000;
	localparam int unsigned RAISE_TIME_NS  = 60000;
	localparam int unsigned SETTLE_CYC     =
		(SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned RAISE_CYC      =
		(RAISE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ****************************************************************
	// register offsets
	// ****************************************************************
	localparam logic [2:0] ADR_CTRL   = 3'h0;
	localparam logic [2:0] ADR_REQ    = 3'h1;
	localparam logic [2:0] ADR_STAT   = 3'h2;
	localparam logic [2:0] ADR_MASK   = 3'h3;
	localparam logic [2:0] ADR_SHARED = 3'h4;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int CTRL_LVL_LSB    = 0;
	localparam int CTRL_LVL_MSB    = 2;
	localparam int CTRL_ON_BIT     = 4;
	localparam int CTRL_FLAG_BIT   = 5;
	localparam int REQ_FLAG_BIT    = 0;
	localparam int REQ_SETTLED_BIT = 1;
	localparam int EV_RAISE_BIT    = 0;
	localparam int EV_RISE_BIT     = 1;
	localparam int EV_FALL_BIT     = 2;
	localparam int EV_W            = 3;
	localparam int SH_FLAG_BIT     = 0;
	localparam int SH_EN_BIT       = 1;

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic [2:0]      LVL_RST  = 3'h0;
	localparam logic            ON_RST   = 1'b0;
	localparam logic            REQ_RST  = 1'b0;
	localparam logic            SH_RST   = 1'b0;
	localparam logic [EV_W-1:0] STAT_RST = 3'h0;
	localparam logic [EV_W-1:0] MASK_RST = 3'h0;
	localparam logic [7:0]      RD_RST   = 8'h00;

	// ****************************************************************
	// types
	// ****************************************************************
	typedef struct packed {
		logic       det_on;
		logic       ref_on;
		logic [2:0] level;
	} slv_ana_s;

	typedef enum logic [1:0] {
		REQ_IDLE,
		REQ_DELAY,
		REQ_HELD
	} slv_req_e;

endpackage

// ---- core/slv_sync.sv ----
`timescale 1ns/1ns
module slv_sync
(
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic en,
	input  wire logic d,
	output logic      q
);

	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic q_q;
	logic q_d;

	// ****************************************************************
	// accept a change once stages two and three agree
	// ****************************************************************
	always_comb
	begin
		q_d = q_q;
		if (s2_q == s3_q)
		begin
			q_d = s3_q;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			q_q  <= 1'b0;
		end
		else if (en)
		begin
			s1_q <= d;
			s2_q <= s1_q;
			s3_q <= s2_q;
			q_q  <= q_d;
		end
	end

	assign q = q_q;

endmodule

// ---- core/slv_core.sv ----
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ns
module slv_core
	import slv_pkg::*;
#(
	parameter int unsigned SETTLE_CYCLES = SETTLE_CYC,
	parameter int unsigned RAISE_CYCLES  = RAISE_CYC
)
(
	input  wire logic       CLK_SYS,
	input  wire logic       SRST,
	input  wire logic       CE,
	input  wire logic [2:0] ADDR,
	input  wire logic [7:0] WDATA,
	input  wire logic       WR,
	input  wire logic       RD,
	output logic      [7:0] RDATA,
	input  wire logic       CMP_LOW,
	input  wire logic       PWR_DOWN,
	input  wire logic       MF_ACK,
	output slv_ana_s        ANA,
	output logic            MF_REQ,
	output logic            WAKE,
	output logic            IRQ
);

	localparam int SW = $clog2(SETTLE_CYCLES + 1);
	localparam int RW = $clog2(RAISE_CYCLES + 1);
	localparam logic [SW-1:0] SETTLE_LOAD = SW'(SETTLE_CYCLES);
	localparam logic [RW-1:0] RAISE_LOAD  = RW'(RAISE_CYCLES - 1);

	logic            cmp_sync;
	logic            low_flag;
	logic            flag_prev_q;
	logic            flag_rise;
	logic            flag_fall;
	logic            settled;
	logic            wr_ctrl;
	logic            wr_req;
	logic            wr_stat;
	logic            wr_mask;
	logic            wr_sh;

	logic [2:0]      lvl_q;
	logic [2:0]      lvl_d;
	logic            on_q;
	logic            on_d;
	logic [SW-1:0]   settle_q;
	logic [SW-1:0]   settle_d;

	slv_req_e        state_q;
	slv_req_e        state_d;
	logic [RW-1:0]   cnt_q;
	logic [RW-1:0]   cnt_d;
	logic            raise;

	logic            req_q;
	logic            req_d;
	logic            req_prev_q;
	logic            req_rise;
	logic            sh_flag_q;
	logic            sh_flag_d;
	logic            sh_en_q;
	logic            sh_en_d;
	logic            wake_q;
	logic            wake_d;

	logic [EV_W-1:0] stat_q;
	logic [EV_W-1:0] stat_d;
	logic [EV_W-1:0] mask_q;
	logic [EV_W-1:0] mask_d;
	logic [EV_W-1:0] ev;
	logic [7:0]      rd_q;
	logic [7:0]      rd_d;

	// ****************************************************************
	// comparator input
	// ****************************************************************
	slv_sync u_sync
	(
		.clk  (CLK_SYS),
		.srst (SRST),
		.en   (CE),
		.d    (CMP_LOW),
		.q    (cmp_sync)
	);

	// filtered in u_sync, gated by enable
	assign low_flag  = on_q & cmp_sync;
	assign flag_rise = low_flag & ~flag_prev_q;
	assign flag_fall = ~low_flag & flag_prev_q;

	// ****************************************************************
	// write decode
	// ****************************************************************
	assign wr_ctrl = WR && (ADDR == ADR_CTRL);
	assign wr_req  = WR && (ADDR == ADR_REQ);
	assign wr_stat = WR && (ADDR == ADR_STAT);
	assign wr_mask = WR && (ADDR == ADR_MASK);
	assign wr_sh   = WR && (ADDR == ADR_SHARED);

	// ****************************************************************
	// control register and settle timer
	// ****************************************************************
	always_comb
	begin
		lvl_d    = lvl_q;
		on_d     = on_q;
		settle_d = settle_q;
		if (wr_ctrl)
		begin
			lvl_d = WDATA[CTRL_LVL_MSB:CTRL_LVL_LSB];
			on_d  = WDATA[CTRL_ON_BIT];
		end
		if (!on_d)
		begin
			settle_d = '0;
		end
		else if (!on_q)
		begin
			settle_d = SETTLE_LOAD;
		end
		else if (settle_q != '0)
		begin
			settle_d = settle_q - SW'(1);
		end
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (SRST)
		begin
			lvl_q    <= LVL_RST;
			on_q     <= ON_RST;
			settle_q <= '0;
		end
		else if (CE)
		begin
			lvl_q    <= lvl_d;
			on_q     <= on_d;
			settle_q <= settle_d;
		end
	end

	assign settled = on_q && (settle_q == '0);

	// analog side: stays on in power-down, reference follows enable
	assign ANA.det_on = on_q;
	assign ANA.ref_on = on_q;
	assign ANA.level  = lvl_q;

	// ****************************************************************
	// request delay
	// ****************************************************************
	always_comb
	begin
		state_d = state_q;
		cnt_d   = cnt_q;
		raise   = 1'b0;
		case (state_q)
			REQ_IDLE:
			begin
				if (flag_rise)
				begin
					state_d = REQ_DELAY;
					cnt_d   = RAISE_LOAD;
				end
			end
			REQ_DELAY:
			begin
				if (!low_flag)
				begin
					state_d = REQ_IDLE;
				end
				else if (cnt_q == '0)
				begin
					raise   = 1'b1;
					state_d = REQ_HELD;
				end
				else
				begin
					cnt_d = cnt_q - RW'(1);
				end
			end
			REQ_HELD:
			begin
				if (!low_flag)
				begin
					state_d = REQ_IDLE;
				end
			end
			default:
			begin
				state_d = REQ_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (SRST)
		begin
			state_q     <= REQ_IDLE;
			cnt_q       <= '0;
			flag_prev_q <= 1'b0;
		end
		else if (CE)
		begin
			state_q     <= state_d;
			cnt_q       <= cnt_d;
			flag_prev_q <= low_flag;
		end
	end

	// ****************************************************************
	// request, shared flag and wake-up
	// ****************************************************************
	assign req_rise = req_q & ~req_prev_q;

	always_comb
	begin
		req_d     = req_q;
		sh_flag_d = sh_flag_q;
		sh_en_d   = sh_en_q;
		wake_d    = 1'b0;
		if (wr_req)
		begin
			req_d = WDATA[REQ_FLAG_BIT];
		end
		if (raise)
		begin
			req_d = 1'b1;
		end
		if (MF_ACK)
		begin
			sh_flag_d = 1'b0;
		end
		if (wr_sh)
		begin
			sh_flag_d = WDATA[SH_FLAG_BIT];
			sh_en_d   = WDATA[SH_EN_BIT];
		end
		if (req_rise)
		begin
			sh_flag_d = 1'b1;
		end
		if (req_rise && PWR_DOWN)
		begin
			wake_d = 1'b1;
		end
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (SRST)
		begin
			req_q      <= REQ_RST;
			req_prev_q <= REQ_RST;
			sh_flag_q  <= SH_RST;
			sh_en_q    <= SH_RST;
			wake_q     <= 1'b0;
		end
		else if (CE)
		begin
			req_q      <= req_d;
			req_prev_q <= req_q;
			sh_flag_q  <= sh_flag_d;
			sh_en_q    <= sh_en_d;
			wake_q     <= wake_d;
		end
	end

	assign MF_REQ = sh_flag_q & sh_en_q;
	assign WAKE   = wake_q;

	// ****************************************************************
	// event status and mask
	// ****************************************************************
	always_comb
	begin
		ev               = '0;
		ev[EV_RAISE_BIT] = raise;
		ev[EV_RISE_BIT]  = flag_rise;
		ev[EV_FALL_BIT]  = flag_fall;
		stat_d           = stat_q;
		mask_d           = mask_q;
		if (wr_stat)
		begin
			stat_d = stat_q & ~WDATA[EV_W-1:0];
		end
		stat_d = stat_d | ev;
		if (wr_mask)
		begin
			mask_d = WDATA[EV_W-1:0];
		end
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (SRST)
		begin
			stat_q <= STAT_RST;
			mask_q <= MASK_RST;
		end
		else if (CE)
		begin
			stat_q <= stat_d;
			mask_q <= mask_d;
		end
	end

	assign IRQ = |(stat_q & mask_q);

	// ****************************************************************
	// read port
	// ****************************************************************
	always_comb
	begin
		rd_d = RD_RST;
		if (RD)
		begin
			case (ADDR)
				ADR_CTRL:
				begin
					rd_d[CTRL_LVL_MSB:CTRL_LVL_LSB] = lvl_q;
					rd_d[CTRL_ON_BIT]                = on_q;
					rd_d[CTRL_FLAG_BIT]              = low_flag;
				end
				ADR_REQ:
				begin
					rd_d[REQ_FLAG_BIT]    = req_q;
					rd_d[REQ_SETTLED_BIT] = settled;
				end
				ADR_STAT:
				begin
					rd_d[EV_W-1:0] = stat_q;
				end
				ADR_MASK:
				begin
					rd_d[EV_W-1:0] = mask_q;
				end
				ADR_SHARED:
				begin
					rd_d[SH_FLAG_BIT] = sh_flag_q;
					rd_d[SH_EN_BIT]   = sh_en_q;
				end
				default:
				begin
					rd_d = RD_RST;
				end
			endcase
		end
	end

	// bits 7:6 and 3 never assigned above
	always_ff @(posedge CLK_SYS)
	begin
		if (SRST)
		begin
			rd_q <= RD_RST;
		end
		else if (CE)
		begin
			rd_q <= rd_d;
		end
	end

	assign RDATA = rd_q;

endmodule

// ---- sim/slv_supply_model.sv ----
`timescale 1ns/1ns
// ****
// supply comparator with own reference
// ****
module slv_supply_model
	import slv_pkg::*;
(
	input  wire slv_ana_s    ana,
	input  wire logic [15:0] vdd_mv,
	output logic             cmp_low
);
	int lvl_mv [8] =
		'{2000, 2200, 2400, 2700, 3000, 3300, 3600, 4400};
	// unpowered comparator or reference never reports low
	assign cmp_low = ana.det_on && ana.ref_on &&
		(vdd_mv < lvl_mv[ana.level]);
endmodule

// ---- sim/slv_core_sva.sv ----
`timescale 1ns/1ns
// ****
// checker on the top ports
// ****
module slv_core_sva
	import slv_pkg::*;
#(
	parameter int unsigned SETTLE_CYCLES = SETTLE_CYC,
	parameter int unsigned RAISE_CYCLES  = RAISE_CYC
)
(
	input wire logic       CLK_SYS,
	input wire logic       SRST,
	input wire logic       CE,
	input wire logic [2:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic       WR,
	input wire logic       RD,
	input wire logic [7:0] RDATA,
	input wire logic       CMP_LOW,
	input wire logic       PWR_DOWN,
	input wire logic       MF_ACK,
	input wire slv_ana_s   ANA,
	input wire logic       MF_REQ,
	input wire logic       WAKE,
	input wire logic       IRQ
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (SRST);
	sequence ctrl_rd;
		RD && CE && ADDR == ADR_CTRL;
	endsequence
	sequence ctrl_wr;
		WR && CE && ADDR == ADR_CTRL;
	endsequence
	a_ctrl_unimpl: assert property (ctrl_rd |=> RDATA[7:6] == 2'h0
		&& RDATA[3] == 1'b0) else $error("unimplemented bits set");
	a_unmapped_zero: assert property (RD && CE && ADDR > 3'h4
		|=> RDATA == 8'h00) else $error("unmapped read not zero");
	a_ref_follows: assert property (ANA.ref_on == ANA.det_on)
		else $error("reference not following detector");
	a_ctrl_write: assert property (ctrl_wr |=>
		ANA.det_on == $past(WDATA[4]) && ANA.level == $past(WDATA[2:0]))
		else $error("control write lost");
	a_off_flag: assert property (ctrl_rd ##0 !ANA.det_on
		|=> !RDATA[5]) else $error("flag set while off");
	a_wake_pulse: assert property (WAKE |=> !WAKE)
		else $error("wake longer than one cycle");
	a_wake_pd: assert property ($rose(WAKE) |-> $past(PWR_DOWN))
		else $error("wake outside power-down");
	a_ack_clears: assert property (MF_ACK && CE |=> !MF_REQ)
		else $error("shared request not cleared");
	a_irq_mask: assert property (WR && CE && ADDR == ADR_MASK
		&& WDATA[2:0] == 3'h0 |=> !IRQ) else $error("masked irq raised");
endmodule
bind slv_core slv_core_sva #(
	.SETTLE_CYCLES(SETTLE_CYCLES),
	.RAISE_CYCLES (RAISE_CYCLES)
) sva_u (
	.CLK_SYS(CLK_SYS), .SRST(SRST), .CE(CE), .ADDR(ADDR), .WDATA(WDATA),
	.WR(WR), .RD(RD), .RDATA(RDATA), .CMP_LOW(CMP_LOW), .PWR_DOWN(PWR_DOWN),
	.MF_ACK(MF_ACK), .ANA(ANA), .MF_REQ(MF_REQ), .WAKE(WAKE), .IRQ(IRQ)
);

// ---- sim/slv_core_test.sv ----
`timescale 1ns/1ns
module slv_core_test
	import slv_pkg::*;
;
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
	mismatches++; $display("mismatch %s exp %h got %h", nm, e, g); end end
	logic        clk    = 1'b0;
	logic        srst   = 1'b1;
	logic        ce     = 1'b1;
	logic        wr     = 1'b0;
	logic        rd     = 1'b0;
	logic        pd     = 1'b0;
	logic        mf_ack = 1'b0;
	logic [2:0]  addr   = 3'h0;
	logic [7:0]  wdata  = 8'h00;
	logic [15:0] vdd    = 16'h1388;
	logic [7:0]  rdata;
	logic        cmp;
	logic        mf_req;
	logic        wake;
	logic        irq;
	slv_ana_s    ana;
	int          mismatches = 0;
	int          n_compared = 0;
	int          wakes      = 0;
	int          lvl_mv [8] =
		'{2000, 2200, 2400, 2700, 3000, 3300, 3600, 4400};
	slv_core #(.SETTLE_CYCLES(4), .RAISE_CYCLES(3)) dut_u (
		.CLK_SYS(clk), .SRST(srst), .CE(ce), .ADDR(addr), .WDATA(wdata),
		.WR(wr), .RD(rd), .RDATA(rdata), .CMP_LOW(cmp), .PWR_DOWN(pd),
		.MF_ACK(mf_ack), .ANA(ana), .MF_REQ(mf_req), .WAKE(wake), .IRQ(irq));
	slv_supply_model sup_u (.ana(ana), .vdd_mv(vdd), .cmp_low(cmp));
	always #50 clk = ~clk;
	always @(posedge clk) if (wake === 1'b1) wakes++;
	// ****
	// bus tasks and verdict
	// ****
	task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic chk_rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		`CHK("rdata", e, rdata)
	endtask
	task automatic report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge clk);
		mismatches++;
		report_and_stop;
	end
	// ****
	// scenarios
	// ****
	initial
	begin
		logic [7:0] d;
		void'($urandom(32'h94d0));
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		chk_rd(ADR_CTRL, 8'h00);
		`CHK("ana", 5'h00, ana)
		chk_rd(3'h6, 8'h00);
		for (int i = 0; i < 8; i++)
		begin
			vdd <= 16'(lvl_mv[i] + (i % 2 ? -50 : 50));
			d = 8'($urandom);
			d[5] = ~i[0];
			d[4] = 1'b1;
			d[2:0] = 3'(i);
			bus_wr(ADR_CTRL, d);
			repeat (6) @(posedge clk);
			chk_rd(ADR_CTRL, {2'h0, i[0], 2'h2, 3'(i)});
			`CHK("ref", 1'b1, ana.ref_on)
		end
		bus_wr(ADR_CTRL, 8'h13);
		for (int k = 0; k < 4; k++)
		begin
			vdd <= k[0] ? 16'h0bb8 : 16'h09c4;
			repeat (6) @(posedge clk);
			chk_rd(ADR_CTRL, {2'h0, !k[0], 5'h13});
		end
		bus_wr(ADR_MASK, 8'h00);
		bus_wr(ADR_REQ, 8'h00);
		bus_wr(ADR_STAT, 8'h07);
		bus_wr(ADR_MASK, 8'h01);
		bus_wr(ADR_SHARED, 8'h02);
		vdd <= 16'h09c4;
		repeat (2) @(posedge clk);
		vdd <= 16'h0bb8;
		repeat (12) @(posedge clk);
		chk_rd(ADR_REQ, 8'h02);
		`CHK("irq", 1'b0, irq)
		chk_rd(ADR_STAT, 8'h06);
		chk_rd(ADR_MASK, 8'h01);
		chk_rd(ADR_SHARED, 8'h02);
		vdd <= 16'h09c4;
		repeat (12) @(posedge clk);
		chk_rd(ADR_REQ, 8'h03);
		`CHK("irq", 1'b1, irq)
		`CHK("mf_req", 1'b1, mf_req)
		@(posedge clk);
		mf_ack <= 1'b1;
		@(posedge clk);
		mf_ack <= 1'b0;
		@(negedge clk);
		`CHK("mf_req", 1'b0, mf_req)
		chk_rd(ADR_REQ, 8'h03);
		@(negedge clk);
		`CHK("rd_idle", 8'h00, rdata)
		bus_wr(ADR_STAT, 8'h07);
		repeat (2) @(negedge clk);
		`CHK("irq", 1'b0, irq)
		vdd <= 16'h0bb8;
		bus_wr(ADR_REQ, 8'h00);
		pd <= 1'b1;
		repeat (8) @(posedge clk);
		wakes = 0;
		vdd <= 16'h09c4;
		repeat (14) @(posedge clk);
		`CHK("wakes", 1, wakes)
		vdd <= 16'h0bb8;
		repeat (8) @(posedge clk);
		bus_wr(ADR_REQ, 8'h00);
		bus_wr(ADR_REQ, 8'h01);
		repeat (4) @(posedge clk);
		`CHK("wakes", 2, wakes)
		vdd <= 16'h09c4;
		repeat (14) @(posedge clk);
		`CHK("wakes", 2, wakes)
		bus_wr(ADR_CTRL, 8'h03);
		bus_wr(ADR_REQ, 8'h00);
		repeat (14) @(posedge clk);
		chk_rd(ADR_CTRL, 8'h03);
		chk_rd(ADR_REQ, 8'h00);
		`CHK("on", 1'b0, ana.det_on)
		@(posedge clk);
		ce <= 1'b0;
		bus_wr(ADR_CTRL, 8'h17);
		ce <= 1'b1;
		chk_rd(ADR_CTRL, 8'h03);
		`CHK("on", 1'b0, ana.det_on)
		report_and_stop;
	end
endmodule
